/* rtc_channel_ctrl.sv */
// Retimer channel control: frequency check, CTLE selection, output mux, divider
`timescale 1ns/1ps
`default_nettype none
module rtc_channel_ctrl #(
  parameter logic [14:0] AUTO_COUNT_G0 = 15'h0000,
  parameter logic [14:0] AUTO_COUNT_G1 = 15'h0000,
  parameter logic [3:0] AUTO_TOL = 4'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire rtc_pkg::rtc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Analog and CDR status
  input wire logic sig_detect,
  input wire logic cdr_locked,
  input wire logic vco_div32_tick,
  input wire logic vco_group_sel,
  input wire logic [1:0] auto_div_code,
  input wire logic [7:0] adapted_ctle,
  // Control outputs
  output var rtc_pkg::rtc_out_s out_ctrl,
  output logic [7:0] ctle_applied,
  output logic [1:0] vco_div_code,
  output logic [14:0] meas_count,
  output logic freq_match,
  output logic freq_done
);
  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] r_boost, r_ovr_a, r_div, r_mux, r_ovr_b, r_low_ctle;
  logic [7:0] r_g0_lo, r_g0_hi, r_g1_lo, r_g1_hi, r_tol;
  logic [7:0] next_boost, next_ovr_a, next_div, next_mux, next_ovr_b, next_low_ctle;
  logic [7:0] next_g0_lo, next_g0_hi, next_g1_lo, next_g1_hi, next_tol, next_rdata;

  // Write decode and read mux; unmapped reads return zero
  always_comb begin
    next_boost = r_boost;
    next_ovr_a = r_ovr_a;
    next_div = r_div;
    next_mux = r_mux;
    next_ovr_b = r_ovr_b;
    next_low_ctle = r_low_ctle;
    next_g0_lo = r_g0_lo;
    next_g0_hi = r_g0_hi;
    next_g1_lo = r_g1_lo;
    next_g1_hi = r_g1_hi;
    next_tol = r_tol;
    if (reg_req.wr) begin
      case (reg_req.addr)
        rtc_pkg::OFS_CTLE_BOOST: next_boost = reg_req.wdata;
        rtc_pkg::OFS_OVR_A: next_ovr_a = reg_req.wdata;
        rtc_pkg::OFS_DIV_SEL: next_div = reg_req.wdata;
        rtc_pkg::OFS_MUX_OVR: next_mux = reg_req.wdata;
        rtc_pkg::OFS_OVR_B: next_ovr_b = reg_req.wdata;
        rtc_pkg::OFS_LOW_RATE_CTLE: next_low_ctle = reg_req.wdata;
        rtc_pkg::OFS_G0_LOW: next_g0_lo = reg_req.wdata;
        rtc_pkg::OFS_G0_HIGH: next_g0_hi = reg_req.wdata;
        rtc_pkg::OFS_G1_LOW: next_g1_lo = reg_req.wdata;
        rtc_pkg::OFS_G1_HIGH: next_g1_hi = reg_req.wdata;
        rtc_pkg::OFS_TOL: next_tol = reg_req.wdata;
        default: next_tol = r_tol;
      endcase
    end
    next_rdata = reg_rdata;
    if (reg_req.rd) begin
      case (reg_req.addr)
        rtc_pkg::OFS_CTLE_BOOST: next_rdata = r_boost;
        rtc_pkg::OFS_OVR_A: next_rdata = r_ovr_a;
        rtc_pkg::OFS_DIV_SEL: next_rdata = r_div;
        rtc_pkg::OFS_MUX_OVR: next_rdata = r_mux;
        rtc_pkg::OFS_OVR_B: next_rdata = r_ovr_b;
        rtc_pkg::OFS_LOW_RATE_CTLE: next_rdata = r_low_ctle;
        rtc_pkg::OFS_CTLE_READBACK: next_rdata = ctle_applied;
        rtc_pkg::OFS_G0_LOW: next_rdata = r_g0_lo;
        rtc_pkg::OFS_G0_HIGH: next_rdata = r_g0_hi;
        rtc_pkg::OFS_G1_LOW: next_rdata = r_g1_lo;
        rtc_pkg::OFS_G1_HIGH: next_rdata = r_g1_hi;
        rtc_pkg::OFS_TOL: next_rdata = r_tol;
        default: next_rdata = rtc_pkg::RST_ZERO;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_boost <= rtc_pkg::RST_ZERO;
      r_ovr_a <= rtc_pkg::RST_ZERO;
      r_div <= rtc_pkg::RST_ZERO;
      r_mux <= rtc_pkg::RST_MUX_OVR;
      r_ovr_b <= rtc_pkg::RST_ZERO;
      r_low_ctle <= rtc_pkg::RST_ZERO;
      r_g0_lo <= rtc_pkg::RST_ZERO;
      r_g0_hi <= rtc_pkg::RST_ZERO;
      r_g1_lo <= rtc_pkg::RST_ZERO;
      r_g1_hi <= rtc_pkg::RST_ZERO;
      r_tol <= rtc_pkg::RST_ZERO;
      reg_rdata <= rtc_pkg::RST_ZERO;
    end else begin
      r_boost <= next_boost;
      r_ovr_a <= next_ovr_a;
      r_div <= next_div;
      r_mux <= next_mux;
      r_ovr_b <= next_ovr_b;
      r_low_ctle <= next_low_ctle;
      r_g0_lo <= next_g0_lo;
      r_g0_hi <= next_g0_hi;
      r_g1_lo <= next_g1_lo;
      r_g1_hi <= next_g1_hi;
      r_tol <= next_tol;
      reg_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Frequency check
  // --------------------------------------------------------------------------
  logic [26:0] ref_acc, next_ref_acc;
  logic [9:0] ref_cnt, next_ref_cnt;
  logic [14:0] vco_cnt, next_vco_cnt, next_meas;
  logic ref_tick, win_end, next_match;
  logic [14:0] exp_g0, exp_g1, exp_sel;
  logic [3:0] tol_sel;
  logic [15:0] lo_bound, hi_bound;

  // Expected counts: manual value only when its enable bit is set
  assign exp_g0 = r_g0_hi[rtc_pkg::BIT_MANUAL_COUNT] ? {r_g0_hi[6:0], r_g0_lo}
                                                     : AUTO_COUNT_G0;
  assign exp_g1 = r_g1_hi[rtc_pkg::BIT_MANUAL_COUNT] ? {r_g1_hi[6:0], r_g1_lo}
                                                     : AUTO_COUNT_G1;
  assign exp_sel = vco_group_sel ? exp_g1 : exp_g0;
  // Tolerance follows the same manual enable as its count
  assign tol_sel = vco_group_sel
      ? (r_g1_hi[rtc_pkg::BIT_MANUAL_COUNT] ? r_tol[rtc_pkg::TOL_G1_LSB +: 4] : AUTO_TOL)
      : (r_g0_hi[rtc_pkg::BIT_MANUAL_COUNT] ? r_tol[rtc_pkg::TOL_G0_LSB +: 4] : AUTO_TOL);
  // One spare bit keeps the sum from wrapping; low bound clamps at zero
  assign lo_bound = ({1'b0, exp_sel} > {12'h000, tol_sel}) ?
                    {1'b0, exp_sel} - {12'h000, tol_sel} : 16'h0000;
  assign hi_bound = {1'b0, exp_sel} + {12'h000, tol_sel};
  // 25 MHz tick from 40 MHz by fractional accumulation, five ticks per eight clocks
  assign ref_tick = (ref_acc + rtc_pkg::REF_STEP) >= rtc_pkg::REF_WRAP;
  assign win_end = ref_tick && (ref_cnt == 10'(rtc_pkg::REF_WINDOW - 1));

  // Window counting, VCO/32 count saturates rather than wrapping
  always_comb begin
    next_ref_acc = ref_acc + rtc_pkg::REF_STEP;
    if (ref_tick) begin
      next_ref_acc = ref_acc + rtc_pkg::REF_STEP - rtc_pkg::REF_WRAP;
    end
    next_ref_cnt = ref_tick ? ref_cnt + 10'h001 : ref_cnt;
    next_vco_cnt = vco_cnt;
    if (vco_div32_tick && vco_cnt != 15'h7FFF) begin
      next_vco_cnt = vco_cnt + 15'h0001;
    end
    next_meas = meas_count;
    next_match = freq_match;
    if (win_end) begin
      next_meas = next_vco_cnt;
      next_match = ({1'b0, next_vco_cnt} >= lo_bound) &&
                   ({1'b0, next_vco_cnt} <= hi_bound);
      next_vco_cnt = 15'h0000;
    end
  end

  // Window state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_acc <= 27'h0000000;
      ref_cnt <= 10'h000;
      vco_cnt <= 15'h0000;
      meas_count <= 15'h0000;
      freq_match <= 1'b0;
      freq_done <= 1'b0;
    end else begin
      ref_acc <= next_ref_acc;
      ref_cnt <= next_ref_cnt;
      vco_cnt <= next_vco_cnt;
      meas_count <= next_meas;
      freq_match <= next_match;
      freq_done <= win_end;
    end
  end

  // --------------------------------------------------------------------------
  // Divider and CTLE selection
  // --------------------------------------------------------------------------
  logic [1:0] next_div_code;
  logic [7:0] next_ctle;

  // Field values above 3 are invalid; the low two bits are taken as they stand
  always_comb begin
    next_div_code = auto_div_code;
    if (r_ovr_a[rtc_pkg::BIT_DIV_OVR_EN]) begin
      next_div_code = r_div[rtc_pkg::DIV_FIELD_LSB +: 2];
    end
    next_ctle = adapted_ctle;
    if (r_ovr_b[rtc_pkg::BIT_CTLE_OVR_EN]) begin
      next_ctle = r_boost;
    end else if (next_div_code == rtc_pkg::DIV_BY_4 || next_div_code == rtc_pkg::DIV_BY_8) begin
      next_ctle = r_low_ctle;
    end
  end

  // Applied values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vco_div_code <= rtc_pkg::DIV_BY_1;
      ctle_applied <= rtc_pkg::RST_ZERO;
    end else begin
      vco_div_code <= next_div_code;
      ctle_applied <= next_ctle;
    end
  end

  // --------------------------------------------------------------------------
  // Output state
  // --------------------------------------------------------------------------
  rtc_pkg::rtc_out_e out_state, next_out_state;

  // Loss of signal beats everything; retimed is the locked default
  always_comb begin
    case (1'b1)
      !sig_detect: next_out_state = rtc_pkg::OUT_OFF;
      !cdr_locked: next_out_state = rtc_pkg::OUT_MUTE;
      (r_ovr_a[rtc_pkg::BIT_MUX_OVR_EN] && !r_mux[rtc_pkg::BIT_MUX_RETIMED]):
        next_out_state = rtc_pkg::OUT_RAW;
      default: next_out_state = rtc_pkg::OUT_RETIMED;
    endcase
  end

  // Output state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_state <= rtc_pkg::OUT_OFF;
    end else begin
      out_state <= next_out_state;
    end
  end

  assign out_ctrl.power_down = (out_state == rtc_pkg::OUT_OFF);
  assign out_ctrl.mute = (out_state == rtc_pkg::OUT_OFF) || (out_state == rtc_pkg::OUT_MUTE);
  assign out_ctrl.sel_retimed = (out_state == rtc_pkg::OUT_RETIMED);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_ref_rate;
    @(posedge clk) disable iff (!resetn)
    ref_tick |-> ##8 ref_tick;
  endproperty
  a_ref_rate: assert property (p_ref_rate) else $error("reference tick period wrong");

  property p_window;
    @(posedge clk) disable iff (!resetn)
    freq_done |-> $past(ref_cnt) == 10'h3FF && ref_cnt == 10'h000;
  endproperty
  a_window: assert property (p_window) else $error("window not 1024 ticks");

  property p_match;
    @(posedge clk) disable iff (!resetn)
    freq_done |-> freq_match == (({1'b0, meas_count} >= $past(lo_bound)) &&
                                 ({1'b0, meas_count} <= $past(hi_bound)));
  endproperty
  a_match: assert property (p_match) else $error("match result wrong");

  property p_manual_g0;
    @(posedge clk) disable iff (!resetn)
    !vco_group_sel && r_g0_hi[rtc_pkg::BIT_MANUAL_COUNT] |->
      hi_bound == {1'b0, r_g0_hi[6:0], r_g0_lo} + {12'h000, r_tol[rtc_pkg::TOL_G0_LSB +: 4]};
  endproperty
  a_manual_g0: assert property (p_manual_g0) else $error("group 0 count wrong");

  property p_ctle_ovr;
    @(posedge clk) disable iff (!resetn)
    r_ovr_b[3] && $stable(r_ovr_b) |=> ctle_applied == $past(r_boost);
  endproperty
  a_ctle_ovr: assert property (p_ctle_ovr) else $error("boost override not applied");

  property p_low_rate;
    @(posedge clk) disable iff (!resetn)
    !r_ovr_b[3] && next_div_code[1] |=> ctle_applied == $past(r_low_ctle);
  endproperty
  a_low_rate: assert property (p_low_rate) else $error("low rate CTLE not applied");

  property p_readback;
    @(posedge clk) disable iff (!resetn)
    reg_req.rd && reg_req.addr == rtc_pkg::OFS_CTLE_READBACK |=> reg_rdata == $past(ctle_applied);
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs");

  property p_no_signal;
    @(posedge clk) disable iff (!resetn)
    !sig_detect |=> out_ctrl.power_down && out_ctrl.mute && !out_ctrl.sel_retimed;
  endproperty
  a_no_signal: assert property (p_no_signal) else $error("channel not powered down");

  property p_unlocked;
    @(posedge clk) disable iff (!resetn)
    sig_detect && !cdr_locked |=> out_ctrl.mute && !out_ctrl.power_down;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("unlocked output not muted");

  property p_retimed;
    @(posedge clk) disable iff (!resetn)
    sig_detect && cdr_locked && !r_ovr_a[5] |=> out_ctrl.sel_retimed && !out_ctrl.mute;
  endproperty
  a_retimed: assert property (p_retimed) else $error("locked default not retimed");

  property p_div_ovr;
    @(posedge clk) disable iff (!resetn)
    r_ovr_a[2] |=> vco_div_code == $past(r_div[5:4]);
  endproperty
  a_div_ovr: assert property (p_div_ovr) else $error("divider override ignored");
endmodule
`default_nettype wire

/* rtc_pkg.sv */
// Constants and types for the retimer channel rate, CTLE and output control block
package rtc_pkg;
  // --------------------------------------------------------------------------
  // Register offsets (channel register set)
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTLE_BOOST = 8'h03;
  localparam logic [7:0] OFS_OVR_A = 8'h09;
  localparam logic [7:0] OFS_DIV_SEL = 8'h18;
  localparam logic [7:0] OFS_MUX_OVR = 8'h1E;
  localparam logic [7:0] OFS_OVR_B = 8'h2D;
  localparam logic [7:0] OFS_LOW_RATE_CTLE = 8'h3A;
  localparam logic [7:0] OFS_CTLE_READBACK = 8'h52;
  localparam logic [7:0] OFS_G0_LOW = 8'h60;
  localparam logic [7:0] OFS_G0_HIGH = 8'h61;
  localparam logic [7:0] OFS_G1_LOW = 8'h62;
  localparam logic [7:0] OFS_G1_HIGH = 8'h63;
  localparam logic [7:0] OFS_TOL = 8'h64;
  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int BIT_DIV_OVR_EN = 2;     // override_control_a
  localparam int BIT_MUX_OVR_EN = 5;     // override_control_a
  localparam int BIT_CTLE_OVR_EN = 3;    // override_control_b
  localparam int BIT_MUX_RETIMED = 7;    // output_mux_override
  localparam int BIT_MANUAL_COUNT = 7;   // groupN_count_high_override
  localparam int DIV_FIELD_LSB = 4;      // vco_divider_select [6:4]
  localparam int TOL_G0_LSB = 4;         // count_tolerance_both_groups [7:4]
  localparam int TOL_G1_LSB = 0;         // count_tolerance_both_groups [3:0]
  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MUX_OVR = 8'h80;
  // --------------------------------------------------------------------------
  // Divider codes and timing
  // --------------------------------------------------------------------------
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;
  localparam logic [1:0] DIV_BY_8 = 2'h3;
  localparam longint CLK_HZ = 40_000_000;
  localparam longint REF_HZ = 25_000_000;
  localparam int REF_WINDOW = 1024;      // reference periods per measurement
  localparam int VCO_PRESCALE = 32;      // VCO divided by this before counting
  localparam logic [26:0] REF_STEP = 27'(REF_HZ / 1000);
  localparam logic [26:0] REF_WRAP = 27'(CLK_HZ / 1000);
  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OUT_OFF = 4'h1,
    OUT_MUTE = 4'h2,
    OUT_RAW = 4'h4,
    OUT_RETIMED = 4'h8
  } rtc_out_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_reg_req_s;
  typedef struct packed {
    logic power_down;
    logic mute;
    logic sel_retimed;
  } rtc_out_s;
endpackage

/* rtc_host_model.sv */
// Controller model that drives byte writes and reads on the channel register port
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output var rtc_pkg::rtc_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  // --------------------------------------------------------------------------
  // Port idle state
  // --------------------------------------------------------------------------
  initial begin
    reg_req = '0;
  end
  // --------------------------------------------------------------------------
  // Byte transfers
  // --------------------------------------------------------------------------
  // One-cycle strobe; idle bus shows inverted values so stale data never passes
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    reg_req = '{1'b1, 1'b0, addr, data};
    @(posedge clk);
    #1;
    reg_req = '{1'b0, 1'b0, ~addr, ~data};
  endtask
  // Read data is registered at the strobe edge and taken just after it
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1;
    reg_req = '{1'b0, 1'b1, addr, ~reg_req.wdata};
    @(posedge clk);
    #1;
    reg_req = '{1'b0, 1'b0, ~addr, reg_req.wdata};
    data = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* retimer_rate_ctle_output_control_tb_top.sv */
// Self-checking testbench for the retimer channel control block
`timescale 1ns/1ps
`default_nettype none
module retimer_rate_ctle_output_control_tb_top;
  logic clk, resetn, sig_detect, cdr_locked, vco_div32_tick, vco_group_sel;
  logic freq_match, freq_done;
  logic [1:0] auto_div_code, vco_div_code;
  logic [7:0] adapted_ctle, ctle_applied, reg_rdata, rd;
  logic [14:0] meas_count;
  rtc_pkg::rtc_reg_req_s reg_req;
  rtc_pkg::rtc_out_s out_ctrl;
  int error_cnt = 0;
  int cmp_count = 0;
  int tick_len = 0;
  int left = 0;
  logic [7:0] ofs [12] = '{rtc_pkg::OFS_CTLE_BOOST, rtc_pkg::OFS_OVR_A, rtc_pkg::OFS_DIV_SEL,
    rtc_pkg::OFS_MUX_OVR, rtc_pkg::OFS_OVR_B, rtc_pkg::OFS_LOW_RATE_CTLE,
    rtc_pkg::OFS_CTLE_READBACK, rtc_pkg::OFS_G0_LOW, rtc_pkg::OFS_G0_HIGH,
    rtc_pkg::OFS_G1_LOW, rtc_pkg::OFS_G1_HIGH, rtc_pkg::OFS_TOL};
  // --------------------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------------------
  rtc_channel_ctrl rtc_channel_ctrl_i (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sig_detect(sig_detect), .cdr_locked(cdr_locked),
    .vco_div32_tick(vco_div32_tick), .vco_group_sel(vco_group_sel),
    .auto_div_code(auto_div_code), .adapted_ctle(adapted_ctle), .out_ctrl(out_ctrl),
    .ctle_applied(ctle_applied), .vco_div_code(vco_div_code), .meas_count(meas_count),
    .freq_match(freq_match), .freq_done(freq_done));
  rtc_host_model rtc_host_model_i (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  // --------------------------------------------------------------------------
  // Clock, tick source and watchdog
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Burst of tick_len ticks placed wholly inside the window after each done
  always @(posedge clk) begin
    #1;
    if (freq_done === 1'b1) left = tick_len;
    vco_div32_tick = (left > 0);
    if (left > 0) left--;
  end
  // Tests need about 25000 cycles
  initial begin
    #(40000 * 25);
    error_cnt++;
    finish_test();
  end
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rtc_host_model_i.reg_write(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rtc_host_model_i.reg_read(a, rd);
    chk_val({8'h00, rd}, {8'h00, exp});
  endtask
  // Status inputs change just after an edge; outputs settle one cycle later
  task automatic status(input logic s, input logic l, input logic [1:0] d);
    sig_detect = s;
    cdr_locked = l;
    auto_div_code = d;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Registered outputs follow a register write one edge later
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (freq_done !== 1'b1 && n < 3000);
    if (n >= 3000) error_cnt++;
  endtask
  task automatic freq_case(input logic g, input logic man, input logic [14:0] e,
                           input logic [3:0] tol, input int k, input logic exp);
    int n;
    tick_len = k;
    vco_group_sel = g;
    wr(g ? rtc_pkg::OFS_G1_LOW : rtc_pkg::OFS_G0_LOW, e[7:0]);
    wr(g ? rtc_pkg::OFS_G1_HIGH : rtc_pkg::OFS_G0_HIGH, {man, e[14:8]});
    wr(rtc_pkg::OFS_TOL, g ? {4'h0, tol} : {tol, 4'h0});
    wait_done(n);
    wait_done(n);
    chk_bit(n == 1638 || n == 1639, 1'b1);
    chk_val({1'b0, meas_count}, 16'(k));
    chk_bit(freq_match, exp);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {sig_detect, cdr_locked, vco_group_sel} = 3'h0;
    auto_div_code = rtc_pkg::DIV_BY_1;
    adapted_ctle = 8'h00;
    repeat (16) @(posedge clk);
    chk_val({13'h0000, out_ctrl}, 16'h0006);
    #1;
    resetn = 1'b1;
    // Reset values, then write every byte register and read back all but the CTLE readback
    for (int i = 0; i < 12; i++)
      rd_chk(ofs[i], ofs[i] == rtc_pkg::OFS_MUX_OVR ? rtc_pkg::RST_MUX_OVR : 8'h00);
    rd_chk(8'h55, 8'h00);
    for (int i = 0; i < 12; i++) wr(ofs[i], 8'hA5 ^ 8'(i));
    for (int i = 0; i < 12; i++) if (i != 6) rd_chk(ofs[i], 8'hA5 ^ 8'(i));
    for (int i = 0; i < 12; i++) wr(ofs[i], ofs[i] == rtc_pkg::OFS_MUX_OVR ? 8'h80 : 8'h00);
    rd_chk(rtc_pkg::OFS_CTLE_READBACK, 8'h00);
    $display("Test registers done");
    // CTLE: adapted, fixed at slow dividers, then overridden
    wr(rtc_pkg::OFS_LOW_RATE_CTLE, 8'h00);
    adapted_ctle = 8'h5A;
    for (int d = 0; d < 4; d++) begin
      status(1'b1, 1'b1, 2'(d));
      chk_val({14'h0000, vco_div_code}, 16'(d));
      chk_val({8'h00, ctle_applied}, d >= 2 ? 16'h0000 : 16'h005A);
    end
    wr(rtc_pkg::OFS_LOW_RATE_CTLE, 8'h17);
    rd_chk(rtc_pkg::OFS_CTLE_READBACK, 8'h17);
    wr(rtc_pkg::OFS_CTLE_BOOST, 8'h33);
    wr(rtc_pkg::OFS_OVR_B, 8'h08);
    rd_chk(rtc_pkg::OFS_CTLE_READBACK, 8'h33);
    chk_val({8'h00, ctle_applied}, 16'h0033);
    wr(rtc_pkg::OFS_OVR_B, 8'h00);
    status(1'b1, 1'b1, rtc_pkg::DIV_BY_1);
    rd_chk(rtc_pkg::OFS_CTLE_READBACK, 8'h5A);
    $display("Test ctle done");
    // Divider field drives the divider only under override
    status(1'b1, 1'b1, rtc_pkg::DIV_BY_2);
    wr(rtc_pkg::OFS_OVR_A, 8'h04);
    for (int d = 0; d < 4; d++) begin
      wr(rtc_pkg::OFS_DIV_SEL, 8'(d << 4));
      step();
      chk_val({14'h0000, vco_div_code}, 16'(d));
    end
    wr(rtc_pkg::OFS_OVR_A, 8'h00);
    status(1'b1, 1'b1, rtc_pkg::DIV_BY_2);
    chk_val({14'h0000, vco_div_code}, 16'h0001);
    $display("Test divider done");
    // Output: power down, mute, retimed and raw selection
    status(1'b0, 1'b1, rtc_pkg::DIV_BY_1);
    chk_bit(out_ctrl.power_down & out_ctrl.mute, 1'b1);
    status(1'b1, 1'b0, rtc_pkg::DIV_BY_1);
    chk_val({14'h0000, out_ctrl.power_down, out_ctrl.mute}, 16'h0001);
    status(1'b1, 1'b1, rtc_pkg::DIV_BY_1);
    chk_val({13'h0000, out_ctrl}, 16'h0001);
    wr(rtc_pkg::OFS_OVR_A, 8'h20);
    wr(rtc_pkg::OFS_MUX_OVR, 8'h00);
    step();
    chk_val({13'h0000, out_ctrl}, 16'h0000);
    wr(rtc_pkg::OFS_MUX_OVR, 8'h80);
    step();
    chk_val({13'h0000, out_ctrl}, 16'h0001);
    $display("Test output done");
    // Frequency check at both tolerance edges, both groups, manual bit clear
    freq_case(1'b0, 1'b1, 15'd1000, 4'h5, 1005, 1'b1);
    freq_case(1'b0, 1'b1, 15'd1000, 4'h5, 1006, 1'b0);
    freq_case(1'b0, 1'b1, 15'd1000, 4'h5, 995, 1'b1);
    freq_case(1'b0, 1'b1, 15'd1000, 4'h5, 994, 1'b0);
    // Expected count from data rate times divider, counted per window
    freq_case(1'b1, 1'b1, 15'(64'd195_312_500 * 2 * rtc_pkg::REF_WINDOW /
              (rtc_pkg::VCO_PRESCALE * rtc_pkg::REF_HZ)), 4'hF, 515, 1'b1);
    freq_case(1'b1, 1'b1, 15'd500, 4'hF, 484, 1'b0);
    freq_case(1'b0, 1'b0, 15'd1000, 4'h5, 1000, 1'b0);
    $display("Test frequency done");
    finish_test();
  end
endmodule
`default_nettype wire
